// ### rtl/cam_status_pkg.sv
package cam_status_pkg;

  // ----------------------------------------------------------------
  // address map, byte addressed over the command link
  // ----------------------------------------------------------------
  localparam logic [15:0] STATUS_BASE = 16'h0c00;
  localparam logic [15:0] AVAIL_OFS = 16'h0000;
  localparam logic [15:0] FLAGS_OFS = 16'h0001;
  localparam logic [15:0] FLAGS_LAST_OFS = 16'h0004;
  localparam logic [15:0] LOGIC_STATUS_BASE = 16'h0c10;
  localparam logic [15:0] LOGIC_STATUS_LAST = 16'h0c11;

  // ----------------------------------------------------------------
  // field values and positions
  // ----------------------------------------------------------------
  localparam logic [7:0] AVAIL_NO = 8'h00;
  localparam logic [7:0] AVAIL_YES = 8'h01;
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
  localparam logic [31:0] FLAGS_USED_MASK = 32'h007b_00fe;
  localparam int BIT_BUSY = 1;
  localparam int BIT_RESET = 2;
  localparam int BIT_PARAM = 3;
  localparam int BIT_USER_SET = 4;
  localparam int BIT_FILE = 5;
  localparam int BIT_SUPPLY = 6;
  localparam int BIT_PROTOCOL = 7;
  localparam int BIT_NOT_READY = 16;
  localparam int BIT_TRIGGER = 17;
  localparam int BIT_SHADING = 19;
  localparam int BIT_OVERTEMP = 20;
  localparam int BIT_LOW_RATE = 21;
  localparam int BIT_INT_OVERVOLT = 22;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } rd_req_type;

  typedef struct packed {
    logic ack;
    logic hit;
    logic [7:0] data;
  } rd_rsp_type;

  typedef struct packed {
    logic user_set_fail;
    logic file_fail;
    logic protocol_err;
    logic logic_not_ready;
    logic trigger_err;
  } event_type;

  typedef struct packed {
    logic supply_fault;
    logic overtemp;
    logic int_overvolt;
  } pin_level_type;

  typedef enum logic {
    SHADE_DARK,
    SHADE_GAIN
  } shade_mode_type;

endpackage

// ### rtl/level_sync.sv
`timescale 1ns/1ps

module level_sync #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // levels in and out
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_type;

  sync_state_type s_q;
  sync_state_type s_d;

  // first stage feeds only the second stage
  always_comb
  begin
    s_d = s_q;
    s_d.meta = async_i;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign sync_o = s_q.stable;

endmodule

// ### rtl/shading_judge.sv
`timescale 1ns/1ps

module shading_judge
  import cam_status_pkg::*;
#(
  parameter int PIX_W = 12,
  parameter logic [PIX_W-1:0] DARK_LIMIT = 12'h100
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // run control
  input wire logic start_i,
  input wire cam_status_pkg::shade_mode_type mode_i,
  input wire logic end_i,
  // captured lines
  input wire logic pix_valid_i,
  input wire logic [PIX_W-1:0] pix_i,
  // verdict
  output logic running_o,
  output logic done_o,
  output logic fail_o
);

  import cam_status_pkg::*;

  typedef enum logic {
    IDLE,
    RUN
  } judge_state_type;

  typedef struct packed {
    judge_state_type state;
    shade_mode_type mode;
    logic [PIX_W-1:0] min_pix;
    logic [PIX_W-1:0] max_pix;
    logic too_bright;
    logic done;
    logic fail;
  } judge_type;

  judge_type s_q;
  judge_type s_d;

  // track extremes over the run; verdict on the end strobe
  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    unique case (s_q.state)
      IDLE:
      begin
        if (start_i)
        begin
          s_d.state = RUN;
          s_d.mode = mode_i;
          s_d.min_pix = '1;
          s_d.max_pix = '0;
          s_d.too_bright = 1'b0;
        end
      end
      RUN:
      begin
        if (pix_valid_i)
        begin
          if (pix_i < s_q.min_pix)
            s_d.min_pix = pix_i;
          if (pix_i > s_q.max_pix)
            s_d.max_pix = pix_i;
          if (pix_i > DARK_LIMIT)
            s_d.too_bright = 1'b1; // [R14]
        end
        if (end_i)
        begin
          s_d.state = IDLE;
          s_d.done = 1'b1;
          // darkest doubled below brightest means under one half
          if (s_q.mode == SHADE_DARK)
            s_d.fail = s_q.too_bright; // [R14]
          else
            s_d.fail = {s_q.min_pix, 1'b0} < {1'b0, s_q.max_pix}; // [R15]
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s_q <= '{IDLE, SHADE_DARK, '1, '0, 1'b0, 1'b0, 1'b0};
    else
      s_q <= s_d;
  end

  assign running_o = (s_q.state == RUN);
  assign done_o = s_q.done;
  assign fail_o = s_q.fail;

endmodule

// ### rtl/camera_error_status_register.sv
`timescale 1ns/1ps

// Notes on behaviour
// R1 - a detected error sets its flag, held until its own clearing event
// R2 - availability byte reads 0x00 when unavailable, 0x01 when available
// R3 - status word is four bytes, bit 0 least significant, one means present
// R4 - bit 1 high while busy with an internal operation
// R5 - bit 2 set once a reset has taken place
// R6 - bit 3 flags a bad parameter; video output is all zero meanwhile
// R7 - bit 4 set when a stored user settings load fails
// R8 - bit 5 set when an internal file operation fails
// R9 - bit 6 shows supply undervoltage or overvoltage now present
// R10 - bit 7 flags a command protocol error, cleared by reading it
// R11 - bit 16 flags logic not ready, cleared by a logic status read
// R12 - bit 17 flags a trigger error, cleared by a logic status read
// R13 - bit 19 flags failed shading generation, cleared by a good run
// R14 - dark offset run fails when captured pixels are too bright
// R15 - gain run fails when darkest pixels are under half the brightest
// R16 - bit 20 high while overtemperature is present
// R17 - bit 21 one while low line rate compensation is active
// R18 - bit 22 high while an internal overvoltage is present
// R19 - the logic status register clearing bits 16 and 17 sits at 0x0c10
// R20 - reserved bits always read zero and ignore events
module camera_error_status_register
  import cam_status_pkg::*;
#(
  parameter int PIX_W = 12,
  parameter logic [PIX_W-1:0] DARK_LIMIT = 12'h100
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // byte reads from the command decoder
  input wire cam_status_pkg::rd_req_type rd_req_i,
  output cam_status_pkg::rd_rsp_type rd_rsp_o,
  // error event pulses from on-chip detectors
  input wire cam_status_pkg::event_type evt_i,
  // on-chip condition levels
  input wire logic busy_i,
  input wire logic param_err_i,
  input wire logic low_rate_comp_i,
  // monitor levels from pins
  input wire cam_status_pkg::pin_level_type pin_level_i,
  // shading generation control
  input wire logic shade_start_i,
  input wire cam_status_pkg::shade_mode_type shade_mode_i,
  input wire logic shade_end_i,
  // video path
  input wire logic vid_valid_i,
  input wire logic [PIX_W-1:0] vid_pix_i,
  output logic vid_valid_o,
  output logic [PIX_W-1:0] vid_pix_o,
  // status word mirror
  output logic [31:0] flags_o
);

  import cam_status_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n;

  // assert at once, release two edges later
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  pin_level_type pin_sync;
  logic shade_running;
  logic shade_done;
  logic shade_fail;

  level_sync #(
    .WIDTH($bits(pin_level_type))
  ) u_pin_sync (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .async_i(pin_level_i),
    .sync_o(pin_sync)
  );

  shading_judge #(
    .PIX_W(PIX_W),
    .DARK_LIMIT(DARK_LIMIT)
  ) u_judge (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .start_i(shade_start_i),
    .mode_i(shade_mode_i),
    .end_i(shade_end_i),
    .pix_valid_i(vid_valid_i),
    .pix_i(vid_pix_i),
    .running_o(shade_running),
    .done_o(shade_done),
    .fail_o(shade_fail)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic avail;
    logic [31:0] sticky;
    logic [31:0] flags;
    logic ack;
    logic hit;
    logic [7:0] data;
    logic vid_valid;
    logic [PIX_W-1:0] vid_pix;
  } status_type;

  status_type s_q;
  status_type s_d;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [15:0] ofs;
  logic own_hit;
  logic logic_status_rd;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic [31:0] live_vec;

  // every read is acked; only the status block hits, neighbours read zero
  assign ofs = rd_req_i.addr - STATUS_BASE;
  assign own_hit = rd_req_i.valid && rd_req_i.addr >= STATUS_BASE
    && ofs <= FLAGS_LAST_OFS;
  assign logic_status_rd = rd_req_i.valid
    && rd_req_i.addr >= LOGIC_STATUS_BASE
    && rd_req_i.addr <= LOGIC_STATUS_LAST; // [R19]

  // ----------------------------------------------------------------
  // flag sources
  // ----------------------------------------------------------------
  // sticky sets; bit 2 is set on every edge after the reset release
  always_comb
  begin
    set_vec = '0;
    set_vec[BIT_RESET] = 1'b1; // [R5]
    set_vec[BIT_USER_SET] = evt_i.user_set_fail; // [R7]
    set_vec[BIT_FILE] = evt_i.file_fail; // [R8]
    set_vec[BIT_PROTOCOL] = evt_i.protocol_err; // [R10]
    set_vec[BIT_NOT_READY] = evt_i.logic_not_ready; // [R11]
    set_vec[BIT_TRIGGER] = evt_i.trigger_err; // [R12]
    set_vec[BIT_SHADING] = shade_done && shade_fail; // [R13]
  end

  // clears; the byte holding bit 7 is the first status byte
  always_comb
  begin
    clr_vec = '0;
    clr_vec[BIT_PROTOCOL] = own_hit && ofs == FLAGS_OFS; // [R10]
    clr_vec[BIT_NOT_READY] = logic_status_rd; // [R11]
    clr_vec[BIT_TRIGGER] = logic_status_rd; // [R12]
    clr_vec[BIT_SHADING] = shade_done && !shade_fail; // [R13]
  end

  // conditions that show only while present
  always_comb
  begin
    live_vec = '0;
    live_vec[BIT_BUSY] = busy_i || shade_running; // [R4]
    live_vec[BIT_PARAM] = param_err_i; // [R6]
    live_vec[BIT_SUPPLY] = pin_sync.supply_fault; // [R9]
    live_vec[BIT_OVERTEMP] = pin_sync.overtemp; // [R16]
    live_vec[BIT_LOW_RATE] = low_rate_comp_i; // [R17]
    live_vec[BIT_INT_OVERVOLT] = pin_sync.int_overvolt; // [R18]
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.avail = 1'b1;
    // set wins over a clear landing in the same cycle
    s_d.sticky = ((s_q.sticky & ~clr_vec) | set_vec)
      & FLAGS_USED_MASK; // [R1] [R20]
    s_d.flags = (s_d.sticky | live_vec) & FLAGS_USED_MASK; // [R3] [R20]
    // reads answer one cycle later with the pre-clear value
    s_d.ack = rd_req_i.valid;
    s_d.hit = own_hit;
    s_d.data = 8'h00;
    if (own_hit)
    begin
      unique case (ofs[2:0])
        3'h0: s_d.data = s_q.avail ? AVAIL_YES : AVAIL_NO; // [R2]
        3'h1: s_d.data = s_q.flags[7:0]; // [R3]
        3'h2: s_d.data = s_q.flags[15:8];
        3'h3: s_d.data = s_q.flags[23:16];
        3'h4: s_d.data = s_q.flags[31:24];
        default: s_d.data = 8'h00;
      endcase
    end
    // black image while a parameter is out of range
    s_d.vid_valid = vid_valid_i;
    s_d.vid_pix = param_err_i ? '0 : vid_pix_i; // [R6]
  end

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '{1'b0, FLAGS_RESET, FLAGS_RESET, 1'b0, 1'b0, 8'h00,
        1'b0, '0};
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rd_rsp_o.ack = s_q.ack;
  assign rd_rsp_o.hit = s_q.hit;
  assign rd_rsp_o.data = s_q.data;
  assign vid_valid_o = s_q.vid_valid;
  assign vid_pix_o = s_q.vid_pix;
  assign flags_o = s_q.flags;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n);

  logic avail_rd;
  logic flag_byte_rd;
  assign avail_rd = own_hit && ofs == AVAIL_OFS;
  assign flag_byte_rd = own_hit && ofs == FLAGS_OFS;

  sequence s_file_fail_seen;
    evt_i.file_fail ##1 flags_o[BIT_FILE];
  endsequence

  property p_sticky_hold;
    s_file_fail_seen |-> ##1 flags_o[BIT_FILE] [*3];
  endproperty
  a_sticky_hold: assert property (p_sticky_hold) // [R1] [R8]
    else $error("file failure flag did not hold");

  property p_avail;
    avail_rd |=> rd_rsp_o.ack && rd_rsp_o.hit
      && rd_rsp_o.data == ($past(s_q.avail) ? AVAIL_YES : AVAIL_NO);
  endproperty
  a_avail: assert property (p_avail) // [R2]
    else $error("availability byte wrong");

  property p_user_set;
    evt_i.user_set_fail |=> flags_o[BIT_USER_SET];
  endproperty
  a_user_set: assert property (p_user_set) // [R7]
    else $error("user set failure not flagged");

  property p_proto_clear;
    flag_byte_rd && !evt_i.protocol_err
      |=> !flags_o[BIT_PROTOCOL] && rd_rsp_o.data[7] == $past(flags_o[7]);
  endproperty
  a_proto_clear: assert property (p_proto_clear) // [R10]
    else $error("protocol flag not cleared on read");

  property p_proto_set_wins;
    evt_i.protocol_err |=> flags_o[BIT_PROTOCOL];
  endproperty
  a_proto_set_wins: assert property (p_proto_set_wins) // [R10]
    else $error("protocol event lost");

  property p_logic_read_clear;
    logic_status_rd && !evt_i.logic_not_ready && !evt_i.trigger_err
      |=> !flags_o[BIT_NOT_READY] && !flags_o[BIT_TRIGGER];
  endproperty
  a_logic_read_clear: assert property (p_logic_read_clear) // [R11] [R12]
    else $error("logic status read did not clear");

  property p_shading;
    shade_done |=> flags_o[BIT_SHADING] == $past(shade_fail);
  endproperty
  a_shading: assert property (p_shading) // [R13]
    else $error("shading flag does not follow verdict");

  property p_black;
    flags_o[BIT_PARAM] |-> vid_pix_o == '0;
  endproperty
  a_black: assert property (p_black) // [R6]
    else $error("video not black during parameter error");

  property p_overtemp;
    pin_level_i.overtemp [*4] |=> flags_o[BIT_OVERTEMP];
  endproperty
  a_overtemp: assert property (p_overtemp) // [R16]
    else $error("overtemperature not shown");

  // pin levels pass two sync stages and the status register
  property p_supply;
    pin_level_i.supply_fault [*4] |=> flags_o[BIT_SUPPLY];
  endproperty
  a_supply: assert property (p_supply) // [R9]
    else $error("supply fault not shown");

  property p_int_overvolt;
    pin_level_i.int_overvolt [*4] |=> flags_o[BIT_INT_OVERVOLT];
  endproperty
  a_int_overvolt: assert property (p_int_overvolt) // [R18]
    else $error("internal overvoltage not shown");

  // same clock level, one register stage behind its source
  property p_low_rate;
    $past(rst_n) |-> flags_o[BIT_LOW_RATE] == $past(low_rate_comp_i);
  endproperty
  a_low_rate: assert property (p_low_rate) // [R17]
    else $error("low rate compensation bit wrong");

  // bit 2 is up from the first settled edge after any reset
  property p_reset_flag;
    $past(rst_n) |-> flags_o[BIT_RESET];
  endproperty
  a_reset_flag: assert property (p_reset_flag) // [R5]
    else $error("reset flag not set after reset");

  // a trigger error must survive a logic status read in its cycle
  property p_trig_set_wins;
    evt_i.trigger_err |=> flags_o[BIT_TRIGGER];
  endproperty
  a_trig_set_wins: assert property (p_trig_set_wins) // [R1] [R12]
    else $error("trigger event lost");

  property p_reserved;
    (flags_o & ~FLAGS_USED_MASK) == 32'h0000_0000;
  endproperty
  a_reserved: assert property (p_reserved) // [R20]
    else $error("reserved status bit set");

  property p_busy;
    shade_running |=> flags_o[BIT_BUSY];
  endproperty
  a_busy: assert property (p_busy) // [R4]
    else $error("busy not shown during shading run");

endmodule

// ### testbench/grabber_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// frame grabber side: issues single byte register reads
// ----------------------------------------------------------------
module grabber_model
  import cam_status_pkg::*;
(
  // clock
  input wire logic clk_i,
  // read port towards the status block
  output cam_status_pkg::rd_req_type req_o,
  input wire cam_status_pkg::rd_rsp_type rsp_i
);
  import cam_status_pkg::*;

  // idle request with a scrambled address so stale values are not trusted
  initial req_o = '{valid: 1'b0, addr: 16'hffff};

  // one read: request for one edge, answer settles just after that edge
  task automatic read_byte(input logic [15:0] addr, output rd_rsp_type rsp);
    @(posedge clk_i);
    req_o <= '{valid: 1'b1, addr: addr};
    @(posedge clk_i);
    req_o <= '{valid: 1'b0, addr: ~addr};
    #1;
    rsp = rsp_i;
  endtask
endmodule

// ### testbench/camera_error_status_register_test.sv
`timescale 1ns/1ps

module camera_error_status_register_test;
  import cam_status_pkg::*;

  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  rd_req_type rd_req;
  rd_rsp_type rd_rsp;
  event_type evt = '0;
  logic busy = 1'b0;
  logic param_err = 1'b0;
  logic low_rate = 1'b0;
  pin_level_type pins = '0;
  logic sh_start = 1'b0;
  logic sh_end = 1'b0;
  shade_mode_type sh_mode = SHADE_DARK;
  logic vid_valid = 1'b0;
  logic [11:0] vid_pix = 12'h000;
  logic vid_valid_o;
  logic [11:0] vid_pix_o;
  logic [31:0] flags;
  logic [31:0] exp_flags = 32'h0000_0004;
  int err_total = 0;
  int samples_checked = 0;

  // free running 40 mhz clock
  initial forever #12.5 ref_clk_i = ~ref_clk_i;

  camera_error_status_register i_dut (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .rd_req_i(rd_req), .rd_rsp_o(rd_rsp), .evt_i(evt),
    .busy_i(busy), .param_err_i(param_err), .low_rate_comp_i(low_rate),
    .pin_level_i(pins), .shade_start_i(sh_start),
    .shade_mode_i(sh_mode), .shade_end_i(sh_end),
    .vid_valid_i(vid_valid), .vid_pix_i(vid_pix),
    .vid_valid_o(vid_valid_o), .vid_pix_o(vid_pix_o), .flags_o(flags)
  );

  grabber_model i_host (.clk_i(ref_clk_i), .req_o(rd_req), .rsp_i(rd_rsp));

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic tick();
    @(posedge ref_clk_i);
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // read one byte and judge handshake, decode and data together
  task automatic rdchk(input string name, input logic [15:0] a,
                       input logic [7:0] e);
    rd_rsp_type r;
    i_host.read_byte(a, r);
    check("ack", 32'(r.ack), 32'h1);
    check("hit", 32'(r.hit), 32'(a >= 16'h0c00 && a <= 16'h0c04));
    check(name, 32'(r.data), 32'(e));
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    tick();
    #1;
    check("flags after reset", flags, 32'h0000_0004);
    rdchk("avail", STATUS_BASE + AVAIL_OFS, AVAIL_YES);
  endtask

  // all event pulses at once, then each clearing path
  task automatic t_events();
    rd_rsp_type r;
    tick();
    evt <= '1;
    tick();
    evt <= '0;
    #1;
    exp_flags = 32'h0003_00b4;
    check("flags sticky", flags, exp_flags);
    for (int i = 0; i < 4; i++)
      rdchk("flag byte", STATUS_BASE + FLAGS_OFS + 16'(i),
            exp_flags[8*i +: 8]);
    exp_flags[BIT_PROTOCOL] = 1'b0;
    check("flags after word read", flags, exp_flags);
    rdchk("logic status", LOGIC_STATUS_BASE, 8'h00);
    exp_flags = 32'h0000_0034;
    check("flags after logic read", flags, exp_flags);
    rdchk("unmapped", 16'h0c05, 8'h00);
    // a trigger error landing with the clearing read must survive it
    fork
      i_host.read_byte(LOGIC_STATUS_BASE, r);
      begin
        tick();
        evt.trigger_err <= 1'b1;
        tick();
        evt.trigger_err <= 1'b0;
      end
    join
    #1;
    check("logic ack", 32'(r.ack), 32'h1);
    exp_flags[BIT_TRIGGER] = 1'b1;
    check("set beats clear", flags, exp_flags);
    rdchk("logic status again", LOGIC_STATUS_BASE, 8'h00);
    exp_flags[BIT_TRIGGER] = 1'b0;
    check("flags after second logic read", flags, exp_flags);
  endtask

  // live levels and the black video during a parameter error
  task automatic t_levels();
    tick();
    busy <= 1'b1;
    param_err <= 1'b1;
    low_rate <= 1'b1;
    pins <= '1;
    vid_valid <= 1'b1;
    vid_pix <= 12'habc;
    repeat (4) tick();
    #1;
    check("levels on", flags,
          exp_flags | 32'h0070_004a);
    check("black pixel", 32'(vid_pix_o), 32'h0);
    check("video valid", 32'(vid_valid_o), 32'h1);
    tick();
    busy <= 1'b0;
    param_err <= 1'b0;
    low_rate <= 1'b0;
    pins <= '0;
    repeat (4) tick();
    #1;
    check("levels off", flags, exp_flags);
    check("pixel passes", 32'(vid_pix_o), 32'habc);
    tick();
    vid_valid <= 1'b0;
  endtask

  // one judging run with two pixels and the expected verdict
  task automatic shade(input shade_mode_type m, input logic [11:0] a,
                       input logic [11:0] b, input logic fail);
    tick();
    sh_start <= 1'b1;
    sh_mode <= m;
    tick();
    sh_start <= 1'b0;
    // the run state is registered, then the status word a cycle later
    tick();
    #1;
    check("busy in run", 32'(flags[BIT_BUSY]), 32'h1);
    tick();
    vid_valid <= 1'b1;
    vid_pix <= a;
    tick();
    vid_pix <= b;
    tick();
    vid_valid <= 1'b0;
    sh_end <= 1'b1;
    tick();
    sh_end <= 1'b0;
    repeat (2) tick();
    #1;
    exp_flags[BIT_SHADING] = fail;
    check("shading verdict", flags, exp_flags);
  endtask

  task automatic t_shading();
    shade(SHADE_DARK, 12'h101, 12'h000, 1'b1);
    shade(SHADE_DARK, 12'h100, 12'h000, 1'b0);
    shade(SHADE_GAIN, 12'h200, 12'h0ff, 1'b1);
    shade(SHADE_GAIN, 12'h200, 12'h100, 1'b0);
  endtask

  // a second reset in mid-run drops the sticky flags and sets bit 2 again
  task automatic t_rereset();
    tick();
    resetn_i <= 1'b0;
    repeat (2) tick();
    resetn_i <= 1'b1;
    repeat (3) tick();
    #1;
    exp_flags = 32'h0000_0004;
    check("flags after second reset", flags, exp_flags);
    rdchk("avail again", STATUS_BASE + AVAIL_OFS, AVAIL_YES);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) tick();
    resetn_i <= 1'b1;
    // a read taken at the first settled edge sees no availability yet
    tick();
    rdchk("avail early", STATUS_BASE + AVAIL_OFS, AVAIL_NO);
    t_reset();
    t_events();
    t_levels();
    t_shading();
    t_rereset();
    tally_and_finish();
  end

  // the whole run needs about a hundred cycles; this cuts a hang short
  initial
  begin
    repeat (5000) tick();
    err_total++;
    tally_and_finish();
  end
endmodule
